// ### rtl/cfm_filter_map.sv
// Purpose: filter enable and object pointer registers with hit routing
// Assumes: write address and data may arrive in either order
// Notes:   unmapped offsets answer with a slave error, read as zero
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

//Behaviour
//- each filter has one enable bit; clear means it accepts nothing
//- a hitting message goes to the object numbered by the 5-bit pointer
//- a pointer only changes while its filter enable is zero
//- each register byte: enable on top, two unused bits, pointer low five
//- unused bits ignore writes and read as zero
//- register k holds filters 4k to 4k+3, lowest in the low byte
//- reset clears every enable and pointer
module cfm_filter_map
   import cfm_pkg::*;
#(
   parameter int NUM_FILTERS = CFM_NUM_FILTERS
)(
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire logic [CFM_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [CFM_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [NUM_FILTERS-1:0] match_in,
   output logic [NUM_FILTERS-1:0]      filter_hit,
   output logic                        object_valid,
   output logic [CFM_PTR_W-1:0]        object_number,
   output logic [NUM_FILTERS-1:0]      filter_enable_any
);

   // all state of the block in one word, registered in one place
   typedef struct packed {
      cfm_slot_t [NUM_FILTERS-1:0] slot;
      logic                        aw_held;
      logic [CFM_ADDR_W-1:0]       aw_addr;
      logic                        w_held;
      logic [31:0]                 w_data;
      logic [3:0]                  w_strb;
      cfm_bus_t                    bus;
      logic [NUM_FILTERS-1:0]      hit;
      logic                        obj_valid;
      logic [CFM_PTR_W-1:0]        obj_num;
   } cfm_state_t;

   cfm_state_t st;
   cfm_state_t next_st;

   // bus geometry: one byte lane per filter, four lanes to a word
   localparam int         LANES    = 4;
   localparam int         LANE_W   = 8;
   // register index for an offset that decodes to nothing; any value
   // above the last register would do, this one is easy to spot
   localparam logic [2:0] IDX_NONE = 3'h7;

   // map a word offset to register index, or flag it unmapped;
   // unaligned offsets fall to the default and are refused as well
   function automatic logic [2:0] reg_index(input logic [CFM_ADDR_W-1:0] a);
      unique case (a)
         CFM_OFF_CTRL0: reg_index = 3'h0;
         CFM_OFF_CTRL1: reg_index = 3'h1;
         CFM_OFF_CTRL2: reg_index = 3'h2;
         default:       reg_index = IDX_NONE;
      endcase
   endfunction

   // the whole block: bus slave, register writes, hit routing
   always_comb
   begin
      logic [2:0] widx;
      logic [2:0] ridx;
      logic [7:0] wbyte;
      logic [7:0] rbyte;
      logic       done;
      int         f;
      widx    = 3'h0;
      ridx    = 3'h0;
      wbyte   = 8'h00;
      rbyte   = 8'h00;
      done    = 1'b0;
      f       = 0;
      next_st = st;

      // capture address and data separately, in either order;
      // the readys drop while a half waits, so a second beat cannot overwrite it
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bus.bvalid && s_axi_bready)
         next_st.bus.bvalid = 1'b0;

      // commit once both halves are held and the response slot is free;
      // waiting on a full response slot keeps each write paired with its answer
      if (st.aw_held && st.w_held && !st.bus.bvalid)
      begin
         widx               = reg_index(st.aw_addr);
         next_st.aw_held    = 1'b0;
         next_st.w_held     = 1'b0;
         next_st.bus.bvalid = 1'b1;
         next_st.bus.bresp  = (widx == IDX_NONE) ? CFM_RESP_SLVERR : CFM_RESP_OKAY;
         if (widx != IDX_NONE)
         begin
            for (int b = 0; b < LANES; b++)
            begin
               f     = int'(widx) * LANES + b;
               wbyte = st.w_data[b*LANE_W +: LANE_W];
               if (st.w_strb[b] && f < NUM_FILTERS)
               begin
                  next_st.slot[f].enable = wbyte[CFM_ENABLE_BIT];
                  // pointer frozen while the filter is live; the enable written in
                  // the same beat does not unlock it, so disable first
                  if (!st.slot[f].enable)
                     next_st.slot[f].ptr = wbyte[CFM_PTR_LSB +: CFM_PTR_W];
               end
            end
         end
      end

      // read: single outstanding, answered the cycle after address is taken;
      // arready stays low while the answer stands, so a clear and a new
      // capture never meet in one cycle
      if (st.bus.rvalid && s_axi_rready)
         next_st.bus.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         ridx               = reg_index(s_axi_araddr);
         next_st.bus.rvalid = 1'b1;
         next_st.bus.rresp  = (ridx == IDX_NONE) ? CFM_RESP_SLVERR : CFM_RESP_OKAY;
         next_st.bus.rdata  = 32'h0000_0000;
         if (ridx != IDX_NONE)
         begin
            for (int b = 0; b < LANES; b++)
            begin
               f     = int'(ridx) * LANES + b;
               rbyte = 8'h00;
               if (f < NUM_FILTERS)
               begin
                  rbyte[CFM_ENABLE_BIT]             = st.slot[f].enable;
                  rbyte[CFM_PTR_LSB +: CFM_PTR_W]   = st.slot[f].ptr;
               end
               next_st.bus.rdata[b*LANE_W +: LANE_W] = rbyte;
            end
         end
      end

      // hit routing: lowest-numbered enabled match wins the object number;
      // a stored zero pointer is passed on as is, keeping it off is up to
      // software, and a disabled filter's pointer is never looked at
      next_st.obj_valid = 1'b0;
      next_st.obj_num   = CFM_PTR_RESET;
      for (int i = NUM_FILTERS - 1; i >= 0; i--)
      begin
         next_st.hit[i] = match_in[i] && st.slot[i].enable;
         if (next_st.hit[i])
         begin
            next_st.obj_valid = 1'b1;
            next_st.obj_num   = st.slot[i].ptr;
         end
      end
   end

   // state register, everything cleared at reset; every filter comes up
   // off with its pointer at the reserved zero, so nothing hits until
   // software has set a filter up
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // handshake outputs; ready drops while a half is held unprocessed
   // answers come straight from flip-flops, only the readys are gates
   assign s_axi_awready = !st.aw_held;
   assign s_axi_wready  = !st.w_held;
   assign s_axi_arready = !st.bus.rvalid;
   assign s_axi_bvalid  = st.bus.bvalid;
   assign s_axi_bresp   = st.bus.bresp;
   assign s_axi_rvalid  = st.bus.rvalid;
   assign s_axi_rresp   = st.bus.rresp;
   assign s_axi_rdata   = st.bus.rdata;
   assign filter_hit    = st.hit;
   assign object_valid  = st.obj_valid;
   assign object_number = st.obj_num;

   // enable view for the matching engine, wired straight out so the
   // engine sees a new enable in the cycle after its write commits
   always_comb
   begin
      for (int i = 0; i < NUM_FILTERS; i++)
         filter_enable_any[i] = st.slot[i].enable;
   end

endmodule

// ### rtl/cfm_pkg.sv
// Purpose: constants and carrier types for the receive filter object map
// Assumes: 32-bit AXI4-Lite register access, twelve filters in three registers
// Notes:   one byte per filter: enable on top, two dead bits, 5-bit pointer
package cfm_pkg;
   localparam int          CFM_NUM_FILTERS = 12;
   localparam int          CFM_NUM_REGS    = 3;
   localparam int          CFM_PTR_W       = 5;
   localparam int          CFM_ADDR_W      = 4;
   localparam int          CFM_ENABLE_BIT  = 7;
   localparam int          CFM_PTR_LSB     = 0;
   localparam logic [3:0]  CFM_OFF_CTRL0   = 4'h0;
   localparam logic [3:0]  CFM_OFF_CTRL1   = 4'h4;
   localparam logic [3:0]  CFM_OFF_CTRL2   = 4'h8;
   localparam logic [4:0]  CFM_PTR_RESET   = 5'h00;
   localparam logic        CFM_EN_RESET    = 1'b0;
   localparam logic [1:0]  CFM_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  CFM_RESP_SLVERR = 2'h2;

   // one filter slot
   typedef struct packed {
      logic                 enable;
      logic [CFM_PTR_W-1:0] ptr;
   } cfm_slot_t;

   // write and read answer channels of the slave
   typedef struct packed {
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } cfm_bus_t;
endpackage

// ### tb/cfm_filter_map_checker.sv
// Purpose: port-level checks on the filter object map
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   pointer locking is only visible through object_number
`timescale 1ns/1ps
module cfm_filter_map_checker
   import cfm_pkg::*;
#(
   parameter int NUM_FILTERS = CFM_NUM_FILTERS
)(
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic [NUM_FILTERS-1:0] match_in,
   input wire logic [NUM_FILTERS-1:0] filter_hit,
   input wire logic [NUM_FILTERS-1:0] filter_enable_any,
   input wire logic                   object_valid,
   input wire logic [CFM_PTR_W-1:0]   object_number
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // read address accepted at this edge
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // hits pass only through enabled filters, one cycle late
   a_hit_gated: assert property (filter_hit == ($past(match_in) & $past(filter_enable_any)))
      else $error("hit without enable");
   a_valid_any_hit: assert property (object_valid == (|filter_hit))
      else $error("object valid wrong");
   a_idle_number_zero: assert property (!object_valid |-> object_number == 5'h00)
      else $error("number without hit");
   a_dead_bits_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'h60606060) == 32'h0)
      else $error("unused bits set");
   a_reset_disabled: assert property ($rose(rst_b) |-> filter_enable_any == '0)
      else $error("enabled after reset");
   // an enabled winner cannot have its pointer moved under it
   a_locked_pointer: assert property (object_valid && filter_hit == $past(filter_hit)
      |-> object_number == $past(object_number))
      else $error("pointer moved while enabled");
   a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read not answered");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule
bind cfm_filter_map cfm_filter_map_checker #(.NUM_FILTERS(NUM_FILTERS)) chk_i (.*);

// ### tb/cfm_filter_map_bench.sv
// Purpose: register and hit-path scenarios for the filter object map
// Assumes: AXI4-Lite master, handshakes judged at the falling edge
// Notes:   each task starts one edge late so no signal is driven twice
`timescale 1ns/1ps
module cfm_filter_map_bench;
   import cfm_pkg::*;
   logic        sys_clk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [11:0] match_in = 12'h000, filter_hit, filter_enable_any;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        object_valid;
   logic [4:0]  object_number;
   int          err_count = 0, checks = 0;
   cfm_filter_map dut (.*);
   always #12.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      if (g !== e)
         err_count++;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one write (w=1) or read; waits are bounded, a hang ends the run
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
      int n;
      logic ta, tw, tr, dn;
      logic [1:0] rp;
      logic [31:0] dt;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 50; n++)
      begin
         @(negedge sys_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tr = s_axi_arvalid & s_axi_arready;
         dn = w ? s_axi_bvalid : s_axi_rvalid;
         rp = w ? s_axi_bresp : s_axi_rresp;
         dt = s_axi_rdata;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (dn) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n >= 50)
         chk(32'h0, 32'h1);
      if (n >= 50)
         test_done;
      if (!w)
         chk(dt, d);
      chk({30'h0, rp}, {30'h0, r});
   endtask
   // match held two cycles, judged after the second sample lands
   task automatic hit(input logic [11:0] m, input logic [11:0] eh, input logic [4:0] en);
      @(posedge sys_clk);
      match_in <= m;
      repeat (2) @(posedge sys_clk);
      match_in <= 12'h000;
      @(negedge sys_clk);
      chk({14'h0, object_valid, object_number, filter_hit}, {14'h0, |eh, en, eh});
   endtask
   task automatic t_reset;
      bus(0, CFM_OFF_CTRL0, 32'h0, 4'hf, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL1, 32'h0, 4'hf, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL2, 32'h0, 4'hf, CFM_RESP_OKAY);
      bus(0, 4'hc, 32'h0, 4'hf, CFM_RESP_SLVERR);
   endtask
   task automatic t_fields;
      bus(1, CFM_OFF_CTRL1, 32'hffffffff, 4'hf, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL1, 32'h9f9f9f9f, 4'hf, CFM_RESP_OKAY);
      bus(1, CFM_OFF_CTRL1, 32'h01010101, 4'hf, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL1, 32'h1f1f1f1f, 4'hf, CFM_RESP_OKAY);
      bus(1, CFM_OFF_CTRL1, 32'h01010385, 4'hf, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL1, 32'h01010385, 4'hf, CFM_RESP_OKAY);
   endtask
   task automatic t_hits;
      hit(12'h030, 12'h010, 5'h05);
      hit(12'h000, 12'h000, 5'h00);
   endtask
   task automatic t_upper;
      bus(1, CFM_OFF_CTRL2, 32'h9effffff, 4'h8, CFM_RESP_OKAY);
      bus(0, CFM_OFF_CTRL2, 32'h9e000000, 4'hf, CFM_RESP_OKAY);
      bus(1, 4'hc, 32'hffffffff, 4'hf, CFM_RESP_SLVERR);
      @(negedge sys_clk);
      chk({20'h0, filter_enable_any}, 32'h00000810);
      hit(12'h830, 12'h810, 5'h05);
      hit(12'h800, 12'h800, 5'h1e);
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset;
      t_fields;
      t_hits;
      t_upper;
      test_done;
   end
endmodule
